// ===== src/two_wire_host_pkg.sv
`default_nettype none
package two_wire_host_pkg;

  // core clock rate
  localparam int CLK_MHZ = 125;
  localparam int CLK_KHZ = 125000;

  // bus free time: both lines high this long
  localparam int FREE_US  = 50;
  localparam int FREE_CYC = FREE_US * CLK_MHZ;

  // clock-low timeout
  localparam int LOW_TO_MS  = 25;
  localparam int LOW_TO_CYC = LOW_TO_MS * CLK_KHZ;

  // counter widths for the two bus watchdogs
  localparam int FREE_W = 16;
  localparam int LOW_W  = 22;

  // shortest half bit period in core cycles (bit rate at most clk/8)
  localparam logic [7:0] MIN_HALF = 8'h04;
  localparam logic [7:0] RST_HALF = 8'h40;

  // bit index of the first bit of a byte
  localparam logic [2:0] BIT_TOP = 3'h7;

  // level of the lines after reset (released, pulled high)
  localparam logic LINE_IDLE = 1'b1;

  // one byte request
  typedef struct packed {
    logic       start; // start (or repeated start) before the byte
    logic       stop;  // stop after the acknowledge
    logic       rd;    // receive the byte instead of sending it
    logic       nack;  // when receiving: answer not-acknowledge
    logic [7:0] data;  // byte to send; address byte has direction in bit 0
  } cmd_s;

  // one byte answer
  typedef struct packed {
    logic [7:0] data;     // byte received (or sent byte read back)
    logic       nack;     // acknowledge slot seen high
    logic       arb_lost; // bus lost to another master
    logic       timeout;  // clock held low too long, transfer dropped
  } rsp_s;

endpackage
`default_nettype wire

// ===== src/two_wire_pin_sync.sv
`default_nettype none
module two_wire_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);
  import two_wire_host_pkg::*;

  // two flops per pin; first stage read only by the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff;
    logic stab_ff;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_ff <= LINE_IDLE;
        stab_ff <= LINE_IDLE;
      end else if (clk_en_in) begin
        meta_ff <= pin_in[i];
        stab_ff <= meta_ff;
      end
    end
    assign sync_out[i] = stab_ff;
  end

endmodule
`default_nettype wire

// ===== src/two_wire_mgmt_bus_host.sv
`default_nettype none
// What this block does
// - both lines only pulled low or released, never driven high.
// - the master starts transfers and supplies every clock pulse.
// - simultaneous masters: bitwise arbitration leaves one winner.
// - whoever sends start plus address becomes master.
// - start, address byte (address bits 7-1, direction bit 0), data, stop.
// - the receiver pulls data low in the acknowledge clock-high.
// - a high data line in acknowledge clock-high is not-acknowledge.
// - direction bit one reads from the slave, zero writes to it.
// - writes send a byte then wait for the slave acknowledge.
// - reads take a byte then the master answers the acknowledge.
// - the master ends with stop and releases the bus.
// - sending high but seeing low: give up, receive rest of byte.
// - clock low over 25 ms is timeout; communication reset at once.
module two_wire_mgmt_bus_host #(
  parameter int FREE_CYC_P   = two_wire_host_pkg::FREE_CYC,
  parameter int LOW_TO_CYC_P = two_wire_host_pkg::LOW_TO_CYC
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     clk_en_in,
  input  wire logic [7:0]               half_div_in,
  input  wire logic                     cmd_valid_in,
  input  wire two_wire_host_pkg::cmd_s  cmd_in,
  output logic                          cmd_ready_out,
  output logic                          rsp_valid_out,
  output two_wire_host_pkg::rsp_s       rsp_out,
  output logic                          bus_busy_out,
  input  wire logic                     scl_in,
  output logic                          scl_out,
  output logic                          scl_oe_out,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_out
);
  import two_wire_host_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT_FREE, ST_START_A, ST_START_B, ST_BIT_LOW, ST_BIT_HIGH,
    ST_LOST_RX, ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_A, ST_STOP_B, ST_STOP_C,
    ST_RS_A, ST_RS_B, ST_DONE
  } state_e;

  logic              scl_s;
  logic              sda_s;
  logic              scl_d_ff;
  logic              sda_d_ff;
  logic              busy_ff;
  logic              nxt_busy;
  logic [FREE_W-1:0] idle_cnt_ff;
  logic [FREE_W-1:0] nxt_idle_cnt;
  logic [LOW_W-1:0]  low_cnt_ff;
  logic [LOW_W-1:0]  nxt_low_cnt;
  logic              start_evt;
  logic              stop_evt;
  logic              timeout_evt;
  logic              scl_rise;
  logic [7:0]        half_ff;
  logic [7:0]        nxt_half;
  logic              half_end;
  state_e            st_ff;
  state_e            nxt_st;
  logic [7:0]        cnt_ff;
  logic [7:0]        nxt_cnt;
  logic [2:0]        bit_ff;
  logic [2:0]        nxt_bit;
  logic [7:0]        sh_ff;
  logic [7:0]        nxt_sh;
  cmd_s              cmd_ff;
  cmd_s              nxt_cmd;
  rsp_s              rsp_ff;
  rsp_s              nxt_rsp;
  logic              rsp_valid_ff;
  logic              nxt_rsp_valid;
  logic              ready_ff;
  logic              nxt_ready;
  logic              own_ff;
  logic              nxt_own;
  logic              scl_oe_ff;
  logic              nxt_scl_oe;
  logic              sda_oe_ff;
  logic              nxt_sda_oe;
  logic              low_lvl_ff;

  // pins come from the bus: two flops first
  two_wire_pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .pin_in      ({scl_in, sda_in}),
    .sync_out    ({scl_s, sda_s})
  );

  // bus events seen on the synchronised lines
  assign start_evt   = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_evt    = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign timeout_evt = ~scl_s & (low_cnt_ff == LOW_W'(LOW_TO_CYC_P - 1));
  assign scl_rise    = scl_s & ~scl_d_ff;
  assign half_end    = (cnt_ff == half_ff - 8'h01);

  // bus monitor: busy flag, free timer, clock-low timer
  always_comb begin
    nxt_busy     = busy_ff;
    nxt_idle_cnt = '0;
    nxt_low_cnt  = '0;
    nxt_half     = (half_div_in < MIN_HALF) ? MIN_HALF : half_div_in;
    if (scl_s && sda_s) begin
      nxt_idle_cnt = idle_cnt_ff;
      if (idle_cnt_ff == FREE_W'(FREE_CYC_P - 1)) begin
        nxt_busy = 1'b0;
      end else begin
        nxt_idle_cnt = idle_cnt_ff + 1'b1;
      end
    end
    if (!scl_s) begin
      nxt_low_cnt = low_cnt_ff;
      if (low_cnt_ff != LOW_W'(LOW_TO_CYC_P)) begin
        nxt_low_cnt = low_cnt_ff + 1'b1;
      end
    end
    if (start_evt) begin
      nxt_busy = 1'b1;
    end else if (stop_evt || timeout_evt) begin
      nxt_busy = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_d_ff    <= LINE_IDLE;
      sda_d_ff    <= LINE_IDLE;
      busy_ff     <= 1'b0;
      idle_cnt_ff <= '0;
      low_cnt_ff  <= '0;
      half_ff     <= RST_HALF;
    end else if (clk_en_in) begin
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
      busy_ff     <= nxt_busy;
      idle_cnt_ff <= nxt_idle_cnt;
      low_cnt_ff  <= nxt_low_cnt;
      half_ff     <= nxt_half;
    end
  end

  // byte sequencer: next values
  always_comb begin
    nxt_st        = st_ff;
    nxt_cnt       = cnt_ff + 8'h01;
    nxt_bit       = bit_ff;
    nxt_sh        = sh_ff;
    nxt_cmd       = cmd_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp_valid = 1'b0;
    nxt_ready     = 1'b0;
    nxt_own       = own_ff;
    nxt_scl_oe    = scl_oe_ff;
    nxt_sda_oe    = sda_oe_ff;
    case (st_ff)
      ST_IDLE: begin
        nxt_cnt   = '0;
        nxt_ready = 1'b1;
        if (cmd_valid_in && ready_ff) begin
          nxt_ready = 1'b0;
          nxt_cmd   = cmd_in;
          nxt_sh    = cmd_in.data;
          nxt_bit   = BIT_TOP;
          nxt_rsp   = '0;
          if (cmd_in.start && own_ff) begin
            nxt_st = ST_RS_A;
          end else if (cmd_in.start) begin
            nxt_st = ST_WAIT_FREE;
          end else begin
            nxt_st = ST_BIT_LOW;
          end
        end
      end
      ST_WAIT_FREE: begin
        nxt_cnt = '0;
        if (!busy_ff && scl_s && sda_s) begin
          nxt_sda_oe = 1'b1;
          nxt_own    = 1'b1;
          nxt_st     = ST_START_A;
        end
      end
      ST_START_A: begin
        if (half_end) begin
          nxt_scl_oe = 1'b1;
          nxt_cnt    = '0;
          nxt_st     = ST_START_B;
        end
      end
      ST_START_B: begin
        if (half_end) begin
          nxt_cnt = '0;
          nxt_st  = ST_BIT_LOW;
        end
      end
      ST_BIT_LOW: begin
        nxt_sda_oe = ~cmd_ff.rd & ~sh_ff[7];
        if (half_end) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = '0;
          nxt_st     = ST_BIT_HIGH;
        end
      end
      ST_BIT_HIGH: begin
        if (cnt_ff == 8'h00) begin
          if (!scl_s) begin
            nxt_cnt = '0;
          end else begin
            nxt_sh = {sh_ff[6:0], sda_s};
            if (!cmd_ff.rd && sh_ff[7] && !sda_s) begin
              nxt_sda_oe       = 1'b0;
              nxt_own          = 1'b0;
              nxt_rsp.arb_lost = 1'b1;
              nxt_st           = ST_LOST_RX;
            end
          end
        end else if (half_end) begin
          nxt_scl_oe = 1'b1;
          nxt_cnt    = '0;
          if (bit_ff == 3'h0) begin
            nxt_st = ST_ACK_LOW;
          end else begin
            nxt_bit = bit_ff - 3'h1;
            nxt_st  = ST_BIT_LOW;
          end
        end
      end
      ST_LOST_RX: begin
        if (bit_ff == 3'h0 || stop_evt) begin
          nxt_rsp.data = sh_ff;
          nxt_st       = ST_DONE;
        end else if (scl_rise) begin
          nxt_sh  = {sh_ff[6:0], sda_s};
          nxt_bit = bit_ff - 3'h1;
        end
      end
      ST_ACK_LOW: begin
        nxt_sda_oe = cmd_ff.rd & ~cmd_ff.nack;
        if (half_end) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = '0;
          nxt_st     = ST_ACK_HIGH;
        end
      end
      ST_ACK_HIGH: begin
        if (cnt_ff == 8'h00) begin
          if (!scl_s) begin
            nxt_cnt = '0;
          end else begin
            nxt_rsp.nack = sda_s;
          end
        end else if (half_end) begin
          nxt_scl_oe   = 1'b1;
          nxt_cnt      = '0;
          nxt_rsp.data = sh_ff;
          nxt_st       = cmd_ff.stop ? ST_STOP_A : ST_DONE;
        end
      end
      ST_STOP_A: begin
        nxt_sda_oe = 1'b1;
        if (half_end) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = '0;
          nxt_st     = ST_STOP_B;
        end
      end
      ST_STOP_B: begin
        if (cnt_ff == 8'h00 && !scl_s) begin
          nxt_cnt = '0;
        end else if (half_end) begin
          nxt_sda_oe = 1'b0;
          nxt_cnt    = '0;
          nxt_st     = ST_STOP_C;
        end
      end
      ST_STOP_C: begin
        if (half_end) begin
          nxt_own = 1'b0;
          nxt_st  = ST_DONE;
        end
      end
      ST_RS_A: begin
        nxt_sda_oe = 1'b0;
        if (half_end) begin
          nxt_scl_oe = 1'b0;
          nxt_cnt    = '0;
          nxt_st     = ST_RS_B;
        end
      end
      ST_RS_B: begin
        if (cnt_ff == 8'h00 && !scl_s) begin
          nxt_cnt = '0;
        end else if (half_end) begin
          nxt_sda_oe = 1'b1;
          nxt_cnt    = '0;
          nxt_st     = ST_START_A;
        end
      end
      ST_DONE: begin
        nxt_sda_oe    = 1'b0;
        nxt_cnt       = '0;
        nxt_rsp_valid = 1'b1;
        nxt_ready     = 1'b1;
        nxt_st        = ST_IDLE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    // clock stuck low: drop everything and let go of the bus
    if (timeout_evt && (st_ff != ST_IDLE || own_ff)) begin
      nxt_scl_oe  = 1'b0;
      nxt_sda_oe  = 1'b0;
      nxt_own     = 1'b0;
      nxt_cnt     = '0;
      if (st_ff != ST_IDLE) begin
        nxt_rsp.timeout = 1'b1;
        nxt_ready       = 1'b0;
        nxt_st          = ST_DONE;
      end
    end
  end

  // byte sequencer: registers, frozen while clock enable is low
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff        <= ST_IDLE;
      cnt_ff       <= '0;
      bit_ff       <= BIT_TOP;
      sh_ff        <= '0;
      cmd_ff       <= '0;
      rsp_ff       <= '0;
      rsp_valid_ff <= 1'b0;
      ready_ff     <= 1'b0;
      own_ff       <= 1'b0;
      scl_oe_ff    <= 1'b0;
      sda_oe_ff    <= 1'b0;
      low_lvl_ff   <= 1'b0;
    end else if (clk_en_in) begin
      st_ff        <= nxt_st;
      cnt_ff       <= nxt_cnt;
      bit_ff       <= nxt_bit;
      sh_ff        <= nxt_sh;
      cmd_ff       <= nxt_cmd;
      rsp_ff       <= nxt_rsp;
      rsp_valid_ff <= nxt_rsp_valid;
      ready_ff     <= nxt_ready;
      own_ff       <= nxt_own;
      scl_oe_ff    <= nxt_scl_oe;
      sda_oe_ff    <= nxt_sda_oe;
      low_lvl_ff   <= 1'b0;
    end
  end

  // open-drain: level is always low, enable pulls the line
  assign scl_out       = low_lvl_ff;
  assign sda_out       = low_lvl_ff;
  assign scl_oe_out    = scl_oe_ff;
  assign sda_oe_out    = sda_oe_ff;
  assign cmd_ready_out = ready_ff;
  assign rsp_valid_out = rsp_valid_ff;
  assign rsp_out       = rsp_ff;
  assign bus_busy_out  = busy_ff;

endmodule
`default_nettype wire

// ===== sim/two_wire_host_assertions.sv
`default_nettype none
module two_wire_host_assertions #(
  parameter int LOW_TO_CYC_P = 200
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic rsp_valid_out,
  input wire logic bus_busy_out,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_out,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [15:0] low_cnt_ff;
  logic [15:0] nxt_low_cnt;
  // length of the current clock-low phase on the wire
  always_comb begin
    nxt_low_cnt = scl_in ? 16'h0000 : low_cnt_ff + 16'h0001;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cnt_ff <= 16'h0000;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end
  AST_OPEN_DRAIN: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
  AST_LOW_MIN: assert property ($rose(scl_oe_out) |-> scl_oe_out [*4])
    else $error("clock low phase too short");
  AST_HIGH_MIN: assert property ($fell(scl_oe_out) |-> !scl_oe_out [*4])
    else $error("clock release too short");
  AST_TAKE_DROP: assert property (cmd_valid_in && cmd_ready_out |=> !cmd_ready_out)
    else $error("ready stayed after take");
  AST_RSP_READY: assert property (rsp_valid_out |-> cmd_ready_out)
    else $error("answer without ready");
  AST_RSP_PULSE: assert property (rsp_valid_out |=> !rsp_valid_out)
    else $error("answer longer than one cycle");
  AST_START_SEEN: assert property ($rose(sda_oe_out) && !scl_oe_out && scl_in
    |-> ##[1:8] bus_busy_out) else $error("own start not seen");
  AST_STOP_SEEN: assert property ($fell(sda_oe_out) && !scl_oe_out && scl_in
    |-> ##[1:8] !bus_busy_out) else $error("own stop not seen");
  AST_LOW_TIMEOUT: assert property (low_cnt_ff == LOW_TO_CYC_P + 8
    |-> !bus_busy_out && !scl_oe_out) else $error("clock-low timeout missed");
endmodule
bind two_wire_mgmt_bus_host two_wire_host_assertions #(.LOW_TO_CYC_P(LOW_TO_CYC_P)) i_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out), .rsp_valid_out(rsp_valid_out),
  .bus_busy_out(bus_busy_out), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out));
`default_nettype wire

// ===== sim/two_wire_slave_model.sv
`default_nettype none
module two_wire_slave_model (
  input  wire logic       core_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] stretch_in,
  input  wire logic       nack_in,
  input  wire logic [7:0] tx_in,
  input  wire logic       rival_in,
  output logic            scl_pull_out,
  output logic            sda_pull_out,
  output logic [7:0]      rx_out,
  output logic            ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int         cnt;
  int         nbyte;
  logic       rd;
  logic       tx;
  logic [7:0] sh;
  logic       scl_pull;
  logic       sda_pull;
  logic       win_scl;
  logic       win_sda;
  // own pulls plus those of the winning rival master
  assign scl_pull_out = scl_pull | win_scl;
  assign sda_pull_out = sda_pull | win_sda;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    win_scl = 1'b0;
    win_sda = 1'b0;
    cnt = 0;
    nbyte = 0;
    rd = 1'b0;
  end
  // start and stop restart the frame
  always @(negedge sda_in) begin
    if (scl_in) begin
      cnt = 0;
      nbyte = 0;
      rd = 1'b0;
    end
  end
  always @(posedge sda_in) begin
    if (scl_in) begin
      cnt = 0;
    end
  end
  // sample data or acknowledge on clock rise
  always @(posedge scl_in) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda_in};
    end else begin
      ack_out = sda_in;
    end
    cnt++;
  end
  // pull lines only low, after clock fall; stretch low phase
  always @(negedge scl_in) begin
    scl_pull = (stretch_in != 8'h00);
    repeat (3) @(posedge core_clk_in);
    if (cnt == 9) begin
      cnt = 0;
      nbyte++;
    end
    tx = rival_in ? (nbyte == 0) : (rd && nbyte > 0 && !(nbyte > 1 && ack_out));
    if (cnt == 8) begin
      if (nbyte == 0) rd = sh[0];
      if (!tx) rx_out = sh;
      sda_pull = !tx && !nack_in && !rival_in;
    end else if (cnt < 8) begin
      sda_pull = tx && !tx_in[7 - cnt];
    end
    repeat (stretch_in) @(posedge core_clk_in);
    scl_pull = 1'b0;
  end
  // winning rival keeps clocking once the host gave up, then ends with stop
  always @(posedge scl_in) begin
    if (rival_in && nbyte == 0 && cnt > 0) begin
      repeat (7) @(posedge core_clk_in);
      if (scl_in && cnt == 9) begin
        win_scl = 1'b1;
        repeat (2) @(posedge core_clk_in);
        win_sda = 1'b1;
        repeat (4) @(posedge core_clk_in);
        win_scl = 1'b0;
        repeat (4) @(posedge core_clk_in);
        win_sda = 1'b0;
      end else if (scl_in) begin
        win_scl = 1'b1;
        repeat (4) @(posedge core_clk_in);
        win_scl = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/two_wire_mgmt_bus_iface_test.sv
`default_nettype none
module two_wire_mgmt_bus_iface_test;
  timeunit 1ns;
  timeprecision 1ps;
  import two_wire_host_pkg::*;
  logic       clk, rst_n, cmd_valid, cmd_ready, rsp_valid, busy, scl_oe, sda_oe;
  logic       scl_pull, sda_pull, nack_sl, rival, ack_seen;
  logic [7:0] half, stretch, tx_byte, rx_byte;
  cmd_s       cmd;
  rsp_s       rsp;
  int         err_count, comparisons;
  wire logic  scl_w = !(scl_oe | scl_pull);
  wire logic  sda_w = !(sda_oe | sda_pull);
  two_wire_mgmt_bus_host #(.FREE_CYC_P(20), .LOW_TO_CYC_P(200)) i_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .half_div_in(half),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_out(rsp), .bus_busy_out(busy), .scl_in(scl_w),
    .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe));
  two_wire_slave_model i_slave (
    .core_clk_in(clk), .scl_in(scl_w), .sda_in(sda_w), .stretch_in(stretch),
    .nack_in(nack_sl), .tx_in(tx_byte), .rival_in(rival), .scl_pull_out(scl_pull),
    .sda_pull_out(sda_pull), .rx_out(rx_byte), .ack_out(ack_seen));
  // core clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one byte request, held until taken, then wait for the answer
  task automatic xfer(input logic s, input logic p, input logic r, input logic nk,
                      input logic [7:0] d);
    int n;
    n = 0;
    cmd = '{start: s, stop: p, rd: r, nack: nk, data: d};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 9000) begin
      err_count++;
      $display("unexpected at %0t: no answer", $time);
    end
  endtask
  task automatic t_write();
    half = 8'h02;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA4);
    check_val(rsp.data, 8'hA4);
    check_val({6'h00, rsp.nack, rsp.arb_lost}, 8'h00);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h5A);
    check_val(rx_byte, 8'h5A);
    check_val({7'h00, busy}, 8'h00);
  endtask
  task automatic t_read();
    tx_byte = 8'hC3;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA5);
    check_val({7'h00, rsp.nack}, 8'h00);
    xfer(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    check_val(rsp.data, 8'hC3);
    check_val({7'h00, ack_seen}, 8'h00);
    xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h00);
    check_val(rsp.data, 8'hC3);
    check_val({7'h00, ack_seen}, 8'h01);
  endtask
  task automatic t_nack();
    nack_sl = 1'b1;
    xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'hA4);
    check_val({7'h00, rsp.nack}, 8'h01);
    nack_sl = 1'b0;
  endtask
  task automatic t_stretch();
    half = 8'h10;
    stretch = 8'h28;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA4);
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h3C);
    check_val(rsp.data, 8'h3C);
    check_val(rx_byte, 8'h3C);
    stretch = 8'h00;
    half = 8'h04;
  endtask
  task automatic t_arb();
    rival = 1'b1;
    tx_byte = 8'h50;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h52);
    check_val({7'h00, rsp.arb_lost}, 8'h01);
    check_val(rsp.data, 8'h50);
    repeat (40) @(negedge clk);
    check_val({7'h00, busy}, 8'h00);
    rival = 1'b0;
  endtask
  task automatic t_timeout();
    stretch = 8'hFA;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'hA4);
    check_val({7'h00, rsp.timeout}, 8'h01);
    check_val({7'h00, busy}, 8'h00);
    stretch = 8'h00;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    half = 8'h04;
    stretch = 8'h00;
    nack_sl = 1'b0;
    rival = 1'b0;
    tx_byte = 8'h00;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_write();
    t_read();
    t_nack();
    t_stretch();
    t_arb();
    t_timeout();
    end_of_test();
  end
  // watchdog, well past the expected run length
  initial begin
    #200000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
`default_nettype wire
